// ===== pehg_pkg.sv
package pehg_pkg;
   localparam int ADDR_W = 8;
   localparam int NUM_MASTERS = 5;
   localparam logic [7:0] BUS_COMMAND_ADDR = 8'h04;
   localparam logic [7:0] PAR_ROUTE_ADDR = 8'h90;
   localparam logic [7:0] ERR_COMMAND_ADDR = 8'h94;
   localparam logic [7:0] CTRL_CONFIG_ADDR = 8'h98;
   localparam logic [7:0] STATUS_ADDR = 8'h9C;
   localparam logic [15:0] BUS_COMMAND_RST = 16'h0000;
   localparam logic [7:0] PAR_ROUTE_RST = 8'h00;
   localparam logic [7:0] ERR_COMMAND_RST = 8'h00;
   localparam logic [15:0] CTRL_CONFIG_RST = 16'h0000;
   localparam int CMD_PERR_EN_BIT = 6;
   localparam int CMD_SERR_EN_BIT = 8;
   localparam int ROUTE_PAR_SERR_BIT = 0;
   localparam int ERROR_COMMAND_REG_SBE_BIT = 0;
   localparam int ERROR_COMMAND_REG_MBE_BIT = 1;
   localparam int ERROR_COMMAND_REG_PERR_BIT = 3;
   localparam int ERROR_COMMAND_REG_GSERR_BIT = 5;
   localparam int CFG_WSD_DIS_BIT = 15;
   localparam int CFG_ECC_MODE_BIT = 0;
   typedef enum logic [1:0] {
      PEHG_IDLE = 2'h0,
      PEHG_FLUSH = 2'h1,
      PEHG_ACK = 2'h3
   } pehg_hold_e;
endpackage : pehg_pkg

// ===== pehg_top.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module pehg_top
   import pehg_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic [31:0] DRV_AD_I,
   input wire logic [3:0] DRV_CBE_I,
   input wire logic DRV_EN_I,
   input wire logic STOP_N_I,
   output logic MASTER_STOP_O,
   output logic PAR_O,
   output logic PAR_OE_O,
   input wire logic [31:0] AD_I,
   input wire logic [3:0] CBE_I,
   input wire logic PAR_I,
   input wire logic ADDR_PHASE_I,
   input wire logic DATA_PHASE_I,
   input wire logic PERR_N_I,
   output logic PERR_N_O,
   output logic PERR_OE_O,
   output logic SERR_OE_O,
   input wire logic ECC_SBE_I,
   input wire logic ECC_MBE_I,
   input wire logic TARGET_ABORT_I,
   input wire logic GRAPHICS_SYSTEM_ERROR_IN_N_I,
   input wire logic BRIDGE_HOLD_REQUEST_N_I,
   output logic BRIDGE_HOLD_ACK_N_O,
   input wire logic POSTED_PENDING_I,
   output logic POST_DISABLE_O,
   input wire logic BRIDGE_WRITE_DONE_I,
   input wire logic SNOOP_BUSY_I,
   output logic WRITE_SNOOP_DONE_N_O,
   input wire logic [NUM_MASTERS-1:0] REQ_N_I,
   output logic [NUM_MASTERS-1:0] GNT_N_O
);
   logic [15:0] bus_command_reg_r;
   logic [7:0] par_route_r;
   logic [7:0] error_command_reg_r;
   logic [15:0] controller_config_reg_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic bus_req;
   logic [31:0] rdata_nxt;
   logic par_r, par_oe_r;
   logic stop_r;
   logic calc_r, chk_data_r, chk_addr_r;
   logic perr_r, perr_d_r;
   logic data_bad, addr_bad;
   logic serr_r, serr_nxt;
   logic [2:0] gserr_sync_r;
   logic gserr_lvl_r;
   pehg_hold_e hold_r;
   logic wsd_pend_r, wsd_r;
   logic [NUM_MASTERS-1:0] gnt_r, gnt_nxt, req;
   logic [NUM_MASTERS:0] lower_req;

   // Every access answers on the second cycle; waitrequest drops once.
   assign bus_req = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = bus_req & ~ack_r;
   assign AVS_READDATA_O = rdata_r;

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (AVS_ADDRESS_I)
         BUS_COMMAND_ADDR: rdata_nxt[15:0] = bus_command_reg_r;
         PAR_ROUTE_ADDR: rdata_nxt[7:0] = par_route_r;
         ERR_COMMAND_ADDR: rdata_nxt[7:0] = error_command_reg_r;
         CTRL_CONFIG_ADDR: rdata_nxt[15:0] = controller_config_reg_r;
         STATUS_ADDR: rdata_nxt[4:0] = {wsd_pend_r, gserr_lvl_r,
            POST_DISABLE_O, ~BRIDGE_HOLD_ACK_N_O, serr_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rdata_r <= 32'h0000_0000;
      end else if (AVS_READ_I && !ack_r) begin
         rdata_r <= rdata_nxt;
      end
   end

   // Writes land on the edge where waitrequest is low.
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         bus_command_reg_r <= BUS_COMMAND_RST;
         par_route_r <= PAR_ROUTE_RST;
         error_command_reg_r <= ERR_COMMAND_RST;
         controller_config_reg_r <= CTRL_CONFIG_RST;
      end else if (AVS_WRITE_I && ack_r) begin
         if (AVS_ADDRESS_I == BUS_COMMAND_ADDR) begin
            if (AVS_BYTEENABLE_I[0]) bus_command_reg_r[7:0] <=
               AVS_WRITEDATA_I[7:0];
            if (AVS_BYTEENABLE_I[1]) bus_command_reg_r[15:8] <=
               AVS_WRITEDATA_I[15:8];
         end
         if (AVS_ADDRESS_I == PAR_ROUTE_ADDR && AVS_BYTEENABLE_I[0]) begin
            par_route_r <= AVS_WRITEDATA_I[7:0];
         end
         if (AVS_ADDRESS_I == ERR_COMMAND_ADDR && AVS_BYTEENABLE_I[0]) begin
            error_command_reg_r <= AVS_WRITEDATA_I[7:0];
         end
         if (AVS_ADDRESS_I == CTRL_CONFIG_ADDR) begin
            if (AVS_BYTEENABLE_I[0]) controller_config_reg_r[7:0] <=
               AVS_WRITEDATA_I[7:0];
            if (AVS_BYTEENABLE_I[1]) controller_config_reg_r[15:8] <=
               AVS_WRITEDATA_I[15:8];
         end
      end
   end

   // Parity trails its data by one clock, as the bus timing demands.
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         par_r <= 1'b0;
         par_oe_r <= 1'b0;
      end else begin
         par_r <= ^{DRV_AD_I, DRV_CBE_I};
         par_oe_r <= DRV_EN_I;
      end
   end
   assign PAR_O = par_r;
   assign PAR_OE_O = par_oe_r;

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         stop_r <= 1'b0;
      end else begin
         stop_r <= DRV_EN_I & ~STOP_N_I;
      end
   end
   assign MASTER_STOP_O = stop_r;

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         calc_r <= 1'b0;
         chk_data_r <= 1'b0;
         chk_addr_r <= 1'b0;
      end else begin
         calc_r <= ^{AD_I, CBE_I};
         chk_data_r <= DATA_PHASE_I;
         chk_addr_r <= ADDR_PHASE_I;
      end
   end
   assign data_bad = chk_data_r & (calc_r != PAR_I);
   assign addr_bad = chk_addr_r & (calc_r != PAR_I);

   // The line is driven one cycle past the pulse so it returns high.
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         perr_r <= 1'b0;
         perr_d_r <= 1'b0;
      end else begin
         perr_r <= data_bad & bus_command_reg_r[CMD_PERR_EN_BIT];
         perr_d_r <= perr_r;
      end
   end
   assign PERR_N_O = ~perr_r;
   assign PERR_OE_O = perr_r | perr_d_r;

   // The graphics error input is asynchronous to this clock.
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         gserr_sync_r <= 3'h0;
         gserr_lvl_r <= 1'b0;
      end else begin
         gserr_sync_r <= {gserr_sync_r[1:0], ~GRAPHICS_SYSTEM_ERROR_IN_N_I};
         if (gserr_sync_r[1] == gserr_sync_r[2]) begin
            gserr_lvl_r <= gserr_sync_r[2];
         end
      end
   end

   always_comb begin
      serr_nxt = 1'b0;
      if (controller_config_reg_r[CFG_ECC_MODE_BIT] &&
          ((ECC_SBE_I && error_command_reg_r[ERROR_COMMAND_REG_SBE_BIT]) ||
           (ECC_MBE_I && error_command_reg_r[ERROR_COMMAND_REG_MBE_BIT]))) begin
         serr_nxt = 1'b1;
      end
      if (TARGET_ABORT_I) begin
         serr_nxt = 1'b1;
      end
      if (addr_bad && bus_command_reg_r[CMD_PERR_EN_BIT] &&
          par_route_r[ROUTE_PAR_SERR_BIT]) begin
         serr_nxt = 1'b1;
      end
      if (!PERR_N_I && error_command_reg_r[ERROR_COMMAND_REG_PERR_BIT]) begin
         serr_nxt = 1'b1;
      end
      if (gserr_lvl_r && error_command_reg_r[ERROR_COMMAND_REG_GSERR_BIT]) begin
         serr_nxt = 1'b1;
      end
      if (!bus_command_reg_r[CMD_SERR_EN_BIT]) begin
         serr_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         serr_r <= 1'b0;
      end else begin
         serr_r <= serr_nxt;
      end
   end
   assign SERR_OE_O = serr_r;

   // Acknowledging with posts still queued could deadlock against ISA.
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         hold_r <= PEHG_IDLE;
      end else begin
         unique case (hold_r)
            PEHG_IDLE: if (!BRIDGE_HOLD_REQUEST_N_I) hold_r <= PEHG_FLUSH;
            PEHG_FLUSH: begin
               if (BRIDGE_HOLD_REQUEST_N_I) begin
                  hold_r <= PEHG_IDLE;
               end else if (!POSTED_PENDING_I) begin
                  hold_r <= PEHG_ACK;
               end
            end
            PEHG_ACK: if (BRIDGE_HOLD_REQUEST_N_I) hold_r <= PEHG_IDLE;
            default: hold_r <= PEHG_IDLE;
         endcase
      end
   end
   assign POST_DISABLE_O = (hold_r != PEHG_IDLE);
   assign BRIDGE_HOLD_ACK_N_O = ~(hold_r == PEHG_ACK);

   // A new bridge write while one is pending is merged: the pulse
   // reports that the last write's snoops are all finished.
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         wsd_pend_r <= 1'b0;
         wsd_r <= 1'b0;
      end else if (controller_config_reg_r[CFG_WSD_DIS_BIT]) begin
         wsd_pend_r <= 1'b0;
         wsd_r <= 1'b0;
      end else begin
         wsd_r <= wsd_pend_r & ~SNOOP_BUSY_I & ~BRIDGE_WRITE_DONE_I;
         if (BRIDGE_WRITE_DONE_I) begin
            wsd_pend_r <= 1'b1;
         end else if (!SNOOP_BUSY_I) begin
            wsd_pend_r <= 1'b0;
         end
      end
   end
   assign WRITE_SNOOP_DONE_N_O = ~wsd_r;

   // Fixed priority, lowest index first; a grant is kept while its
   // request stays low, and nobody is granted while the bridge holds.
   assign req = ~REQ_N_I;
   assign lower_req[0] = 1'b0;
   generate
      for (genvar g = 0; g < NUM_MASTERS; g++) begin : g_arb
         assign lower_req[g+1] = lower_req[g] | req[g];
         assign gnt_nxt[g] = (hold_r == PEHG_IDLE) && req[g] &&
            ((|(gnt_r & req)) ? gnt_r[g] : !lower_req[g]);
      end
   endgenerate

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         gnt_r <= '0;
      end else begin
         gnt_r <= gnt_nxt;
      end
   end
   assign GNT_N_O = ~gnt_r;

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);

   sequence s_abort_seen;
      TARGET_ABORT_I && bus_command_reg_r[CMD_SERR_EN_BIT];
   endsequence

   a_par_even: assert property (
      DRV_EN_I |=> PAR_OE_O && PAR_O == ^{$past(DRV_AD_I), $past(DRV_CBE_I)})
      else $error("Driven parity is not even.");
   a_perr_timing: assert property (
      DATA_PHASE_I && bus_command_reg_r[CMD_PERR_EN_BIT] ##1
      (calc_r != PAR_I) && bus_command_reg_r[CMD_PERR_EN_BIT] |=> !PERR_N_O)
      else $error("Parity error not pulsed one clock after parity.");
   a_perr_gate: assert property (
      !PERR_N_O |-> $past(bus_command_reg_r[CMD_PERR_EN_BIT]))
      else $error("Parity error driven while response disabled.");
   a_serr_global: assert property (
      SERR_OE_O |-> $past(bus_command_reg_r[CMD_SERR_EN_BIT]))
      else $error("System error driven while globally disabled.");
   a_serr_ecc: assert property (
      ECC_MBE_I && error_command_reg_r[ERROR_COMMAND_REG_MBE_BIT] &&
      controller_config_reg_r[CFG_ECC_MODE_BIT] &&
      bus_command_reg_r[CMD_SERR_EN_BIT] |=> SERR_OE_O)
      else $error("ECC error did not raise system error.");
   a_abort_pulse: assert property (
      s_abort_seen ##1 !serr_nxt |-> SERR_OE_O ##1 !SERR_OE_O)
      else $error("Target abort system error is not one clock.");
   a_addr_par: assert property (
      SERR_OE_O && !$past(TARGET_ABORT_I) && !$past(ECC_SBE_I) &&
      !$past(ECC_MBE_I) && $past(PERR_N_I) && !$past(gserr_lvl_r) |->
      $past(addr_bad) && $past(par_route_r[ROUTE_PAR_SERR_BIT]) &&
      $past(bus_command_reg_r[CMD_PERR_EN_BIT]))
      else $error("System error without an enabled cause.");
   a_perr_serr: assert property (
      !PERR_N_I && error_command_reg_r[ERROR_COMMAND_REG_PERR_BIT] &&
      bus_command_reg_r[CMD_SERR_EN_BIT] |=> SERR_OE_O)
      else $error("Sampled parity error not forwarded.");
   a_hold_flush: assert property (
      !BRIDGE_HOLD_ACK_N_O |-> POST_DISABLE_O &&
      (!$past(BRIDGE_HOLD_ACK_N_O) || !$past(POSTED_PENDING_I)))
      else $error("Hold acknowledged before posts flushed.");
   a_wsd_off: assert property (
      $past(controller_config_reg_r[CFG_WSD_DIS_BIT]) |->
      WRITE_SNOOP_DONE_N_O)
      else $error("Write snoop done while disabled.");
   a_gnt_onehot: assert property (
      $onehot0(gnt_r) && ((gnt_r & $past(REQ_N_I)) == '0))
      else $error("Grant not one-hot or without request.");
   a_stop_honour: assert property (
      DRV_EN_I && !STOP_N_I |=> MASTER_STOP_O)
      else $error("Target stop was not honoured.");
endmodule : pehg_top

// ===== pehg_far_model.sv
`timescale 1ns/1ps
module pehg_far_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic hold_want_i,
   input wire logic [4:0] bus_want_i,
   output logic hold_req_n_o,
   output logic [4:0] req_n_o
);
   // Requests move only just after an edge, so the bench sees a one cycle
   // lag between asking the model and the pins changing.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hold_req_n_o <= 1'b1;
         req_n_o <= 5'h1F;
      end else begin
         hold_req_n_o <= ~hold_want_i;
         req_n_o <= ~bus_want_i;
      end
   end
endmodule : pehg_far_model

// ===== test_pci_error_hold_and_grant_logic.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   errors++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_pci_error_hold_and_grant_logic
   import pehg_pkg::*;
;
   logic clk = 0, nrst = 0, rd = 0, wr = 0, wrq, den = 0, par = 0, ape = 0;
   logic dpe = 0, perr_ni = 1, perr_no, serr, sbe = 0, mbe = 0, abrt = 0;
   logic gse_n = 1, hreq_n, hack_n, ppend = 0, pdis, bwd = 0, sbusy = 0;
   logic wsd_n, hold_want = 0, par_o, par_oe, perr_oe, mstop, stop_n = 1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rdat, dad = 32'h0000_0000;
   logic [31:0] ad = 32'h0000_0000;
   logic [3:0] dcbe = 4'h0, cbe = 4'h0;
   logic [4:0] req_n, gnt_n, bus_want = 5'h00;
   int errors = 0, total_checks = 0;
   always #2 clk = ~clk;
   pehg_top pehg_top_i (.CLOCK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF),
      .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wrq),
      .DRV_AD_I(dad), .DRV_CBE_I(dcbe), .DRV_EN_I(den), .PAR_O(par_o),
      .STOP_N_I(stop_n), .MASTER_STOP_O(mstop),
      .PAR_OE_O(par_oe), .AD_I(ad), .CBE_I(cbe), .PAR_I(par),
      .ADDR_PHASE_I(ape), .DATA_PHASE_I(dpe), .PERR_N_I(perr_ni),
      .PERR_N_O(perr_no), .PERR_OE_O(perr_oe), .SERR_OE_O(serr),
      .ECC_SBE_I(sbe), .ECC_MBE_I(mbe), .TARGET_ABORT_I(abrt),
      .GRAPHICS_SYSTEM_ERROR_IN_N_I(gse_n), .BRIDGE_HOLD_REQUEST_N_I(hreq_n),
      .BRIDGE_HOLD_ACK_N_O(hack_n), .POSTED_PENDING_I(ppend),
      .POST_DISABLE_O(pdis), .BRIDGE_WRITE_DONE_I(bwd),
      .SNOOP_BUSY_I(sbusy), .WRITE_SNOOP_DONE_N_O(wsd_n), .REQ_N_I(req_n),
      .GNT_N_O(gnt_n));
   pehg_far_model pehg_far_model_i (.clk_i(clk), .nrst_i(nrst),
      .hold_want_i(hold_want), .bus_want_i(bus_want),
      .hold_req_n_o(hreq_n), .req_n_o(req_n));
   task automatic final_report;
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   // Holds the request until waitrequest is sampled low, never longer
   // than the bound, so a stuck slave ends the run instead of hanging it.
   task automatic avs(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      rd <= ~w; wr <= w; addr <= a; wd <= d;
      n = 0;
      do begin @(posedge clk); n++; end while (wrq !== 1'b0 && n < 20);
      if (wrq !== 1'b0) begin errors++; final_report(); end
      q = rdat;
      rd <= 1'b0; wr <= 1'b0;
   endtask : avs
   task automatic cfg(input logic [15:0] c, input logic [7:0] r, e,
      input logic [15:0] p);
      logic [31:0] q;
      avs(1, BUS_COMMAND_ADDR, {16'h0000, c}, q);
      avs(1, PAR_ROUTE_ADDR, {24'h00_0000, r}, q);
      avs(1, ERR_COMMAND_ADDR, {24'h00_0000, e}, q);
      avs(1, CTRL_CONFIG_ADDR, {16'h0000, p}, q);
   endtask : cfg
   task automatic t_regs;
      logic [31:0] q;
      avs(0, BUS_COMMAND_ADDR, 0, q); `CHK("cmd_rst", 32'h0000_0000, q)
      avs(0, PAR_ROUTE_ADDR, 0, q); `CHK("route_rst", 32'h0000_0000, q)
      avs(1, BUS_COMMAND_ADDR, 32'hFFFF_FFFF, q);
      avs(0, BUS_COMMAND_ADDR, 0, q); `CHK("cmd_rw", 32'h0000_FFFF, q)
      avs(1, PAR_ROUTE_ADDR, 32'hFFFF_FFFF, q);
      avs(0, PAR_ROUTE_ADDR, 0, q); `CHK("route_rw", 32'h0000_00FF, q)
      avs(1, 8'h40, 32'hFFFF_FFFF, q);
      avs(0, 8'h40, 0, q); `CHK("unmapped", 32'h0000_0000, q)
      cfg(16'h0000, 8'h00, 8'h00, 16'h0000);
   endtask : t_regs
   task automatic t_pargen;
      logic [35:0] v [4] = '{36'h0_0000_0000, 36'h1_0000_0001,
         36'hF_FFFF_FFFE, 36'h8_0000_0000};
      for (int i = 0; i <= 4; i++) begin
         @(posedge clk);
         den <= (i < 4);
         {dcbe, dad} <= v[i % 4];
         @(negedge clk);
         if (i > 0) begin
            `CHK("par", ^v[i - 1], par_o)
            `CHK("par_oe", 1'b1, par_oe)
         end
      end
   endtask : t_pargen
   task automatic t_stop(input logic d);
      @(posedge clk); den <= d; stop_n <= 1'b0;
      @(posedge clk); den <= 1'b0; stop_n <= 1'b1;
      @(negedge clk); `CHK("stop", d, mstop)
      @(negedge clk); `CHK("stop_end", 1'b0, mstop)
   endtask : t_stop
   task automatic t_par(input logic a, b, ep, es);
      @(posedge clk);
      ad <= 32'hA5A5_0F0F; cbe <= 4'h6; ape <= a; dpe <= ~a;
      @(posedge clk);
      ape <= 1'b0; dpe <= 1'b0; par <= b ^ (^{32'hA5A5_0F0F, 4'h6});
      @(posedge clk);
      par <= ^{32'hA5A5_0F0F, 4'h6};
      @(negedge clk);
      if (!a) `CHK("perr_n", ep, perr_no)
      `CHK("perr_oe", ~ep, perr_oe)
      `CHK("serr_par", es, serr)
      @(negedge clk); `CHK("perr_hold", ~ep, perr_oe)
      `CHK("perr_off", 1'b1, perr_no)
   endtask : t_par
   task automatic t_cause(input int k, input logic e);
      @(posedge clk);
      sbe <= (k == 0); mbe <= (k == 1); abrt <= (k == 2); perr_ni <= (k != 3);
      @(posedge clk);
      sbe <= 1'b0; mbe <= 1'b0; abrt <= 1'b0; perr_ni <= 1'b1;
      @(negedge clk); `CHK("serr", e, serr)
      @(negedge clk); `CHK("serr_one", 1'b0, serr)
   endtask : t_cause
   task automatic t_gfx(input logic [7:0] e, input logic x);
      int n;
      cfg(16'h0100, 8'h00, e, 16'h0000);
      @(posedge clk); gse_n <= 1'b0;
      n = 0;
      do begin @(negedge clk); n++; end while (serr !== 1'b1 && n < 8);
      `CHK("gfx_serr", x, serr)
      @(posedge clk); gse_n <= 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk); `CHK("gfx_clear", 1'b0, serr)
   endtask : t_gfx
   task automatic t_hold;
      int n;
      @(posedge clk); ppend <= 1'b1; hold_want <= 1'b1; bus_want <= 5'h04;
      repeat (6) @(posedge clk);
      @(negedge clk);
      `CHK("ack_early", 1'b1, hack_n)
      `CHK("post_dis", 1'b1, pdis)
      `CHK("gnt_held", 5'h1F, gnt_n)
      @(posedge clk); ppend <= 1'b0;
      n = 0;
      do begin @(negedge clk); n++; end while (hack_n !== 1'b0 && n < 4);
      `CHK("ack", 1'b0, hack_n)
      `CHK("post_dis_ack", 1'b1, pdis)
      @(posedge clk); hold_want <= 1'b0; bus_want <= 5'h0A;
      repeat (5) @(posedge clk);
      @(negedge clk);
      `CHK("ack_off", 1'b1, hack_n)
      `CHK("gnt", 5'h1D, gnt_n)
      @(posedge clk); bus_want <= 5'h00;
   endtask : t_hold
   task automatic t_wsc(input logic dis);
      int n;
      cfg(16'h0000, 8'h00, 8'h00, {dis, 15'h0000});
      @(posedge clk); sbusy <= 1'b1; bwd <= 1'b1;
      @(posedge clk); bwd <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk); `CHK("wsd_busy", 1'b1, wsd_n)
      @(posedge clk); sbusy <= 1'b0;
      n = 0;
      do begin @(negedge clk); n++; end while (wsd_n !== 1'b0 && n < 5);
      `CHK("wsd", dis, wsd_n)
      @(negedge clk); `CHK("wsd_pulse", 1'b1, wsd_n)
   endtask : t_wsc
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_pargen();
      t_stop(1'b1);
      t_stop(1'b0);
      cfg(16'h0040, 8'h00, 8'h00, 16'h0000);
      t_par(0, 1, 1'b0, 1'b0);
      t_par(0, 0, 1'b1, 1'b0);
      cfg(16'h0000, 8'h00, 8'h00, 16'h0000);
      t_par(0, 1, 1'b1, 1'b0);
      cfg(16'h0140, 8'h01, 8'h00, 16'h0000);
      t_par(1, 1, 1'b1, 1'b1);
      cfg(16'h0140, 8'h00, 8'h00, 16'h0000);
      t_par(1, 1, 1'b1, 1'b0);
      cfg(16'h0040, 8'h01, 8'h0B, 16'h0001);
      for (int k = 0; k < 4; k++) t_cause(k, 1'b0);
      cfg(16'h0100, 8'h00, 8'h0B, 16'h0001);
      for (int k = 0; k < 4; k++) t_cause(k, 1'b1);
      cfg(16'h0100, 8'h00, 8'h00, 16'h0001);
      for (int k = 0; k < 4; k++) t_cause(k, k == 2);
      cfg(16'h0100, 8'h00, 8'h03, 16'h0000);
      for (int k = 0; k < 2; k++) t_cause(k, 1'b0);
      t_gfx(8'h20, 1'b1);
      t_gfx(8'h00, 1'b0);
      t_hold();
      t_wsc(1'b0);
      t_wsc(1'b1);
      final_report();
   end
endmodule : test_pci_error_hold_and_grant_logic
